// File: logic/sssc_top.sv
`timescale 1ns/1ps
// Operation
// - Selected only when a low, b high, c low.
// - Any single failing select means deselected.
// - Strap picks linear or interleaved burst order.
// - Disqualified edge is a stall, no write.
// - Data lines high impedance on sleep exit.
// - Sleep holds low power, array kept.
module sssc_top #(
  parameter int ADDR_W = sssc_pkg::ADDR_W,
  parameter int DATA_W = sssc_pkg::DATA_W
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire sssc_pkg::sssc_cmd_type cmd_in,
  input wire logic clock_qualify_n_in,
  input wire logic burst_order_in,
  input wire logic sleep_request_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic selected_out,
  output logic asleep_out
);
  import sssc_pkg::*;

  // The package struct fixes the address width, so only the default is served.
  if (ADDR_W != sssc_pkg::ADDR_W || DATA_W != sssc_pkg::DATA_W) begin : g_width_check
    $error("sssc_top: widths must match the command carrier");
  end

  logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];
  logic [2:0] sleep_sync_r;
  logic sleep_q;
  sssc_pwr_type pwr_r;
  logic chip_sel;
  logic qualified;
  logic [ADDR_W-1:0] base_r;
  logic [BURST_W-1:0] cnt_r;
  logic [BURST_W-1:0] cnt_nxt;
  logic [ADDR_W-1:0] cur_addr;
  logic wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [READ_LAT-1:0] rd_pipe_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] dq_out_r;
  logic last_wr_r;

  // The sleep pin comes from outside; a level counts once stages two and three agree.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_sync_r <= 3'h0;
    end else begin
      sleep_sync_r <= {sleep_sync_r[1:0], sleep_request_in};
    end
  end
  assign sleep_q = (sleep_sync_r[2] == sleep_sync_r[1]) ? sleep_sync_r[2] : (pwr_r == SSSC_ASLEEP);

  // Combined select decode; any failing term deselects.
  assign chip_sel = !cmd_in.chip_select_a_n && cmd_in.chip_select_b && !cmd_in.chip_select_c_n;
  // A disqualified edge reads and writes nothing and freezes the pipeline, except that sleep clears the read pipe bits.
  assign qualified = !clock_qualify_n_in && (pwr_r == SSSC_AWAKE) && !sleep_q;

  // Power state follows the filtered sleep level.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_r <= SSSC_AWAKE;
    end else begin
      case (pwr_r)
        SSSC_AWAKE: if (sleep_q) pwr_r <= SSSC_ASLEEP;
        SSSC_ASLEEP: if (!sleep_q) pwr_r <= SSSC_AWAKE;
        default: pwr_r <= SSSC_AWAKE;
      endcase
    end
  end

  // Address of the next burst beat. Only the low bits step, so a burst wraps inside
  // its aligned group and never spills into the neighbouring one.
  assign cnt_nxt = cnt_r + BURST_W'(1);
  assign cur_addr = (burst_order_in == BURST_INTERLEAVED) ?
      {base_r[ADDR_W-1:BURST_W], base_r[BURST_W-1:0] ^ cnt_nxt} :
      {base_r[ADDR_W-1:BURST_W], base_r[BURST_W-1:0] + cnt_nxt};
  // Burst address: load takes a new base, otherwise the count advances.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_r <= '0;
      cnt_r <= '0;
      last_wr_r <= 1'b0;
    end else if (qualified && chip_sel) begin
      if (cmd_in.load) begin
        base_r <= cmd_in.addr;
        cnt_r <= '0;
        last_wr_r <= !cmd_in.write_n;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // Writes take data one qualified edge after the command, as the bus turns round.
  // The address is captured with the command, so later stalls cannot disturb it.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else if (qualified) begin
      wr_pend_r <= chip_sel && (cmd_in.load ? !cmd_in.write_n : last_wr_r);
      wr_addr_r <= cmd_in.load ? cmd_in.addr : cur_addr;
    end
  end
  // The array has no reset, so its contents survive sleep and stalls alike.
  always_ff @(posedge core_clk_in) begin
    if (qualified && wr_pend_r) begin
      mem_r[wr_addr_r] <= dq_in;
    end
  end

  // Read pipeline: fetch then output register, both frozen by a stall.
  // Every qualified edge fetches; only a read sets the pipe bit that drives the pins.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pipe_r <= '0;
      rd_data_r <= '0;
      dq_out_r <= '0;
    end else if (pwr_r == SSSC_ASLEEP || sleep_q) begin
      rd_pipe_r <= '0;
    end else if (qualified) begin
      rd_pipe_r <= {rd_pipe_r[0],
                    chip_sel && (cmd_in.load ? cmd_in.write_n : !last_wr_r)};
      rd_data_r <= mem_r[cmd_in.load ? cmd_in.addr : cur_addr];
      dq_out_r <= rd_data_r;
    end
  end

  assign dq_out = dq_out_r;
  assign dq_oe_n_out = !rd_pipe_r[READ_LAT-1];
  assign selected_out = chip_sel;
  assign asleep_out = (pwr_r == SSSC_ASLEEP);

  // A stall freezes the output pipeline. Sleep entry is left out, because it
  // clears the pipeline on purpose whatever the qualifier does.
  stall_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (clock_qualify_n_in && !asleep_out && !sleep_q) |=>
      $stable(dq_out_r) && $stable(rd_pipe_r))
    else $error("pipeline moved during stall");
  // A stalled edge writes nothing.
  stall_nowrite_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    clock_qualify_n_in |-> !(qualified && wr_pend_r))
    else $error("write on stalled edge");
  // A stall also keeps a pending write and the burst position for the next edge.
  stall_state_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    clock_qualify_n_in |=> $stable(wr_pend_r) && $stable(wr_addr_r) &&
      $stable(base_r) && $stable(cnt_r))
    else $error("pending state moved during stall");
  // Select decode, checked against all three terms at once.
  select_on_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    selected_out ==
      (!cmd_in.chip_select_a_n && cmd_in.chip_select_b && !cmd_in.chip_select_c_n))
    else $error("select decode wrong");
  // Any one failing term is enough to deselect.
  deselect_any_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (cmd_in.chip_select_a_n || !cmd_in.chip_select_b || cmd_in.chip_select_c_n) |->
      !selected_out)
    else $error("selected despite failing term");
  // A deselected qualified edge starts neither a read nor a write.
  deselect_idle_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (qualified && !chip_sel) |=> !rd_pipe_r[0] && !wr_pend_r)
    else $error("deselected edge started an access");
  // Data lines stay released on the first two edges after sleep exit.
  sleep_hiz_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(asleep_out) |-> dq_oe_n_out [*2])
    else $error("drive on sleep exit");
  // Waking finds an empty read pipeline, so nothing stale is driven.
  wake_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    asleep_out |=> (rd_pipe_r == '0))
    else $error("read pipeline kept through sleep");
  // Two agreeing filter stages high put the device to sleep at the next edge.
  sleep_entry_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (sleep_sync_r[2] && sleep_sync_r[1] && !asleep_out) |=> asleep_out)
    else $error("sleep not entered");
  // It stays asleep while the filtered level is high.
  sleep_stay_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (asleep_out && sleep_sync_r[2] && sleep_sync_r[1]) |=> asleep_out)
    else $error("left sleep early");
  // A filter that disagrees changes nothing, so a glitch on the pin is ignored.
  sleep_filter_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (sleep_sync_r[2] != sleep_sync_r[1]) |=> $stable(asleep_out))
    else $error("power state moved on an unsettled level");
  // Asleep, no edge is qualified, so the array cannot be written.
  sleep_nowrite_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    asleep_out |-> !qualified)
    else $error("edge qualified while asleep");
  // Each burst continuation steps the count once.
  burst_step_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (qualified && chip_sel && !cmd_in.load) |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("burst counter did not advance");
  // Interleaved order: the low address bits are the base bits xor the count.
  burst_xor_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (qualified && chip_sel && !cmd_in.load && (burst_order_in == BURST_INTERLEAVED)) |=>
      ((wr_addr_r[BURST_W-1:0] ^ base_r[BURST_W-1:0]) == cnt_r))
    else $error("interleaved burst address wrong");
  // Linear order: the low bits are the base bits plus the count, wrapping in the group.
  burst_lin_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (qualified && chip_sel && !cmd_in.load && (burst_order_in == BURST_LINEAR)) |=>
      ((wr_addr_r[BURST_W-1:0] - base_r[BURST_W-1:0]) == cnt_r) &&
      (wr_addr_r[ADDR_W-1:BURST_W] == base_r[ADDR_W-1:BURST_W]))
    else $error("linear burst address wrong");

  // Main scenarios: a read driven out, a stall over a live pipeline, a sleep exit,
  // an interleaved burst at its last beat and a burst write beat.
  read_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) $fell(dq_oe_n_out));
  stall_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    clock_qualify_n_in && rd_pipe_r != '0);
  sleep_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) $fell(asleep_out));
  burst_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cnt_r == 2'h3 && burst_order_in);
  burst_wr_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    qualified && chip_sel && !cmd_in.load && wr_pend_r);
endmodule : sssc_top

// File: common/sssc_pkg.sv
package sssc_pkg;
  // Array shape and data width of the modelled memory.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 18;
  localparam int BURST_W = 2;
  // Burst order strap encodings.
  localparam logic BURST_LINEAR = 1'b0;
  localparam logic BURST_INTERLEAVED = 1'b1;
  // Pipeline latency from an accepted read to data on the pins.
  localparam int READ_LAT = 2;

  // One command as sampled on a qualified clock edge.
  typedef struct packed {
    logic chip_select_a_n;
    logic chip_select_b;
    logic chip_select_c_n;
    logic write_n;
    logic load;
    logic [ADDR_W-1:0] addr;
  } sssc_cmd_type;

  // Power state of the device.
  typedef enum logic [1:0] {
    SSSC_AWAKE,
    SSSC_ASLEEP
  } sssc_pwr_type;
endpackage : sssc_pkg

// File: testbench/sssc_host_model.sv
`timescale 1ns/1ps
// Controller stand-in; it moves pins only just after a rising edge.
module sssc_host_model import sssc_pkg::*; (
  input wire logic clk_in,
  output sssc_cmd_type cmd_out,
  output logic qual_n_out,
  output logic sleep_out,
  output logic [DATA_W-1:0] dq_out
);
  // Sleep is driven firmly low, as the pin has no pull-down.
  initial begin
    cmd_out = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
    qual_n_out = 1'b0;
    sleep_out = 1'b0;
    dq_out = 18'h0;
  end
  // Unused data toggles so a stale word never looks valid.
  task automatic cyc(input sssc_cmd_type c, input logic q, input logic [DATA_W-1:0] d,
                     input logic v);
    @(posedge clk_in);
    cmd_out <= c;
    qual_n_out <= q;
    dq_out <= v ? d : ~dq_out;
  endtask : cyc
  // Sleep changes only together with a deselect.
  task automatic sleep(input logic s);
    @(posedge clk_in);
    cmd_out.chip_select_a_n <= 1'b1;
    sleep_out <= s;
  endtask : sleep
endmodule : sssc_host_model

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sssc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sssc_cmd_type cmd;
  logic qual_n, slp, oe_n, sel, asleep;
  logic bo = 1'b0;
  logic [DATA_W-1:0] dq_w, dq_r;
  int fails = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  always #20 clk = ~clk;
  sssc_host_model i_host (.clk_in(clk), .cmd_out(cmd), .qual_n_out(qual_n),
    .sleep_out(slp), .dq_out(dq_w));
  sssc_top i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .cmd_in(cmd),
    .clock_qualify_n_in(qual_n), .burst_order_in(bo), .sleep_request_in(slp),
    .dq_in(dq_w), .dq_out(dq_r), .dq_oe_n_out(oe_n), .selected_out(sel),
    .asleep_out(asleep));
  function automatic sssc_cmd_type cm(input logic [2:0] s, input logic w, input logic [7:0] a);
    return '{s[2], s[1], s[0], w, 1'b1, a};
  endfunction : cm
  // Selected burst continuation; the access kind follows the last loaded command.
  function automatic sssc_cmd_type bc();
    return '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00};
  endfunction : bc
  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
    cmp_count++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask : chk
  task automatic id(input logic q);
    i_host.cyc(cm(3'b101, 1'b1, 8'hff), q, 18'h0, 1'b0);
  endtask : id
  task automatic rd(input logic [7:0] a, input logic [DATA_W-1:0] e);
    i_host.cyc(cm(3'b010, 1'b1, a), 1'b0, 18'h0, 1'b0);
    repeat (2) id(1'b0);
    #1 chk("read", e, dq_r);
    chk("read drive", 1'b0, oe_n);
  endtask : rd
  // Stalled edges keep every select pattern harmless.
  task automatic t_select();
    for (int i = 0; i < 8; i++) begin
      i_host.cyc(cm(i[2:0], 1'b0, 8'h00), 1'b1, 18'h0, 1'b0);
      #1 chk("selected", (i == 2), sel);
    end
    $display("t_select done");
  endtask : t_select
  task automatic t_stall();
    i_host.cyc(cm(3'b010, 1'b0, 8'h21), 1'b0, 18'h0, 1'b0);
    i_host.cyc(cm(3'b101, 1'b1, 8'hff), 1'b0, 18'h2a5a5, 1'b1);
    i_host.cyc(cm(3'b010, 1'b0, 8'h21), 1'b1, 18'h0, 1'b0);
    i_host.cyc(cm(3'b101, 1'b1, 8'hff), 1'b0, 18'h15a5a, 1'b1);
    i_host.cyc(cm(3'b010, 1'b1, 8'h21), 1'b0, 18'h0, 1'b0);
    id(1'b1);
    id(1'b0);
    id(1'b1);
    #1 chk("stall read", 18'h2a5a5, dq_r);
    chk("drive", 1'b0, oe_n);
    id(1'b0);
    #1 chk("held read", 18'h2a5a5, dq_r);
    chk("held drive", 1'b0, oe_n);
    $display("t_stall done");
  endtask : t_stall
  // Linear burst write from an odd base, then an interleaved burst read of it.
  task automatic t_burst();
    i_host.cyc(cm(3'b010, 1'b0, 8'h45), 1'b0, 18'h0, 1'b0);
    i_host.cyc(bc(), 1'b0, 18'h00111, 1'b1);
    i_host.cyc(bc(), 1'b0, 18'h00222, 1'b1);
    i_host.cyc(bc(), 1'b0, 18'h00333, 1'b1);
    i_host.cyc(cm(3'b101, 1'b1, 8'hff), 1'b0, 18'h00444, 1'b1);
    @(posedge clk);
    bo <= 1'b1;
    i_host.cyc(cm(3'b010, 1'b1, 8'h45), 1'b0, 18'h0, 1'b0);
    i_host.cyc(bc(), 1'b0, 18'h0, 1'b0);
    i_host.cyc(bc(), 1'b0, 18'h0, 1'b0);
    #1 chk("burst beat 0", 18'h00111, dq_r);
    chk("burst drive", 1'b0, oe_n);
    i_host.cyc(bc(), 1'b0, 18'h0, 1'b0);
    #1 chk("burst beat 1", 18'h00444, dq_r);
    id(1'b0);
    #1 chk("burst beat 2", 18'h00333, dq_r);
    id(1'b0);
    #1 chk("burst beat 3", 18'h00222, dq_r);
    $display("t_burst done");
  endtask : t_burst
  task automatic t_sleep();
    i_host.sleep(1'b1);
    repeat (6) id(1'b0);
    #1 chk("asleep", 1'b1, asleep);
    i_host.sleep(1'b0);
    repeat (6) id(1'b0);
    #1 chk("wake drive", 1'b1, oe_n);
    chk("awake", 1'b0, asleep);
    rd(8'h21, 18'h2a5a5);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // A hang counts as a mismatch; the tests need well under 200 cycles.
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 2000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_select();
    t_stall();
    t_burst();
    t_sleep();
    finish_test();
  end
endmodule : tb_top
